// file: smw_pkg.sv
/*
  Shared constants and types for the single-master wrapper and its fabric partner.
  Assumes both ends see one bus clock and one active-low asynchronous reset.
*/
// Function
// - Single-master side treats bus as always owned
// - Unused request output of such master left open
// - Grant input of such master tied high
// - Single-master side sees only OKAY or ERROR
// - Lock follows request timing, retimed from the single-master address-phase lock
// - Lock held constant for a whole burst
// - Lock still driven toward multi-port slaves
// - Single-master clock enable comes from ready
// - Bus request derived from transfer type
// - Wrapper handles ownership loss, early end, SPLIT/RETRY
// - Rebuild remaining burst after early termination
// - Keep last address, restart after SPLIT/RETRY
// - Slaves accept bursts that end early
// - Burst type and increment signalled, first beat addressed
package smw_pkg;

  localparam logic [1:0] TR_IDLE   = 2'h0;
  localparam logic [1:0] TR_BUSY   = 2'h1;
  localparam logic [1:0] TR_NONSEQ = 2'h2;
  localparam logic [1:0] TR_SEQ    = 2'h3;

  localparam logic [2:0] BU_SINGLE = 3'h0;
  localparam logic [2:0] BU_INCR   = 3'h1;

  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_ERROR = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [1:0] RESP_SPLIT = 2'h3;

  // Cycles the fabric withholds grant after a SPLIT answer
  localparam logic [3:0] SPLIT_HOLD_CYC = 4'h4;

  typedef enum logic [2:0] {
    PH_WAIT,
    PH_ADDR,
    PH_DATA,
    PH_ERR,
    PH_RETRY
  } smw_phase_t;

  typedef enum logic {
    FS_OK,
    FS_RESP2
  } smw_fab_t;

endpackage

// file: smw_ahb_if.sv
/*
  Full multi-master bus signals between the wrapper and the fabric.
  Assumes the testbench supplies the shared clock and reset to both ends.
*/
`timescale 1ns/100ps
interface smw_ahb_if #(
  parameter int AW = 32,
  parameter int DW = 32
);
  logic          hbusreq;
  logic          hlock;
  logic          hgrant;
  logic [1:0]    htrans;
  logic [AW-1:0] haddr;
  logic          hwrite;
  logic [2:0]    hsize;
  logic [2:0]    hburst;
  logic [DW-1:0] hwdata;
  logic          hready;
  logic [1:0]    hresp;
  logic [DW-1:0] hrdata;

  modport mst (
    output hbusreq, hlock, htrans, haddr, hwrite, hsize, hburst, hwdata,
    input  hgrant, hready, hresp, hrdata
  );

  modport fab (
    input  hbusreq, hlock, htrans, haddr, hwrite, hsize, hburst, hwdata,
    output hgrant, hready, hresp, hrdata
  );
endinterface

// file: smw_wrapper.sv
/*
  Wrapper letting a single-master bus master run on a full multi-master bus.
  Handles one transfer at a time; assumes the single-master side holds its
  address, control and write data while ready is low.
*/
`timescale 1ns/100ps
module smw_wrapper
  import smw_pkg::*;
#(
  parameter int AW = 32,
  parameter int DW = 32
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rstn,
  smw_ahb_if.mst             bus,
  input  wire logic [1:0]    i_lite_htrans,
  input  wire logic [AW-1:0] i_lite_haddr,
  input  wire logic          i_lite_hwrite,
  input  wire logic [2:0]    i_lite_hsize,
  input  wire logic [2:0]    i_lite_hburst,
  input  wire logic          i_lite_hmastlock,
  input  wire logic [DW-1:0] i_lite_hwdata,
  output logic               o_lite_hready,
  output logic               o_lite_hresp,
  output logic [DW-1:0]      o_lite_hrdata
);

  smw_phase_t    phase;
  logic          p_valid;
  logic          p_seq;
  logic          p_write;
  logic [AW-1:0] p_addr;
  logic [2:0]    p_size;
  logic [2:0]    p_burst;
  logic          burst_open;

  logic [1:0]    next_htrans;
  logic          next_open;
  logic [2:0]    next_burst;

  wire lite_take = o_lite_hready & i_lite_htrans[1];
  wire lite_end  = o_lite_hready & (i_lite_htrans == TR_IDLE);
  wire grant_now = bus.hgrant & bus.hready;
  wire seq_ok    = burst_open & p_seq;
  wire issue     = (phase == PH_WAIT) & p_valid & grant_now;
  wire bad_resp  = (phase == PH_DATA) & ~bus.hready & (bus.hresp != RESP_OKAY);
  wire is_error  = bus.hresp == RESP_ERROR;
  wire done      = (phase == PH_DATA) & bus.hready;
  wire err_end   = (phase == PH_ERR) & bus.hready;
  wire addr_took = (phase == PH_ADDR) & bus.hready;
  wire keep_open = (phase == PH_ADDR) ? (p_burst != BU_SINGLE) : burst_open;

  // Pending copy of the single-master address phase, kept until the bus completes it
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      p_valid <= 1'b0;
      p_seq   <= 1'b0;
      p_write <= 1'b0;
      p_addr  <= '0;
      p_size  <= 3'h0;
      p_burst <= BU_SINGLE;
    end else if (lite_take) begin
      p_valid <= 1'b1;
      p_seq   <= i_lite_htrans == TR_SEQ;
      p_write <= i_lite_hwrite;
      p_addr  <= i_lite_haddr;
      p_size  <= i_lite_hsize;
      p_burst <= i_lite_hburst;
    end else if (done | err_end) begin
      p_valid <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      phase <= PH_WAIT;
    end else begin
      case (phase)
        PH_WAIT: begin
          if (issue) begin
            phase <= PH_ADDR;
          end
        end
        PH_ADDR: begin
          if (bus.hready) begin
            phase <= PH_DATA;
          end
        end
        PH_DATA: begin
          if (bus.hready) begin
            phase <= PH_WAIT;
          end else if (bad_resp) begin
            phase <= is_error ? PH_ERR : PH_RETRY;
          end
        end
        default: begin
          // Retry leaves the pending copy in place so the same address reissues
          if (bus.hready) begin
            phase <= PH_WAIT;
          end
        end
      endcase
    end
  end

  // Transfer type toward the full bus; BUSY fills gaps so a burst survives
  always_comb begin
    next_htrans = TR_IDLE;
    next_open   = 1'b0;
    if (issue) begin
      next_htrans = seq_ok ? TR_SEQ : TR_NONSEQ;
      next_open   = burst_open;
    end else if (!bus.hready) begin
      next_htrans = bad_resp ? TR_IDLE : bus.htrans;
      next_open   = bad_resp ? 1'b0 : burst_open;
    end else if (grant_now && keep_open && !lite_end) begin
      next_htrans = TR_BUSY;
      next_open   = 1'b1;
    end
  end

  // Continuation after a lost grant or retry starts over as an open-ended burst
  always_comb begin
    next_burst = bus.hburst;
    if (issue) begin
      if (seq_ok) begin
        next_burst = bus.hburst;
      end else if (p_seq) begin
        next_burst = BU_INCR;
      end else begin
        next_burst = p_burst;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      bus.htrans <= TR_IDLE;
      bus.hburst <= BU_SINGLE;
      burst_open <= 1'b0;
      bus.haddr  <= '0;
      bus.hwrite <= 1'b0;
      bus.hsize  <= 3'h0;
    end else begin
      bus.htrans <= next_htrans;
      bus.hburst <= next_burst;
      burst_open <= next_open;
      if (issue) begin
        bus.haddr  <= p_addr;
        bus.hwrite <= p_write;
        bus.hsize  <= p_size;
      end
    end
  end

  // Request and lock toward the arbiter
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      bus.hbusreq <= 1'b0;
      bus.hlock   <= 1'b0;
      bus.hwdata  <= '0;
    end else begin
      bus.hbusreq <= lite_take | p_valid | next_open;
      // Only sampled outside a burst, so lock cannot change mid-burst
      if (o_lite_hready && i_lite_htrans != TR_SEQ && i_lite_htrans != TR_BUSY) begin
        bus.hlock <= i_lite_hmastlock;
      end
      if (addr_took) begin
        bus.hwdata <= i_lite_hwdata;
      end
    end
  end

  // Ready doubles as the single-master clock enable; SPLIT/RETRY never reach it
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_lite_hready <= 1'b1;
      o_lite_hresp  <= 1'b0;
      o_lite_hrdata <= '0;
    end else begin
      if (lite_take) begin
        o_lite_hready <= 1'b0;
      end else if (done || err_end) begin
        o_lite_hready <= 1'b1;
      end
      if (bad_resp && is_error) begin
        o_lite_hresp <= 1'b1;
      end else if (o_lite_hready) begin
        o_lite_hresp <= 1'b0;
      end
      if (done) begin
        o_lite_hrdata <= bus.hrdata;
      end
    end
  end

endmodule // smw_wrapper

// file: smw_fabric.sv
/*
  Full-bus partner: arbiter for one master plus a small memory slave whose
  answer to each transfer is chosen from the user side.
  Assumes the wrapper is the only master on the bus.
*/
`timescale 1ns/100ps
module smw_fabric
  import smw_pkg::*;
#(
  parameter int AW        = 32,
  parameter int DW        = 32,
  parameter int MEM_WORDS = 16
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rstn,
  smw_ahb_if.fab             bus,
  input  wire logic          i_grant_hold,
  input  wire logic [1:0]    i_resp_sel,
  output logic [AW-1:0]      o_addr_seen,
  output logic [1:0]         o_trans_seen,
  output logic [2:0]         o_burst_seen,
  output logic               o_lock_seen
);

  localparam int IW = $clog2(MEM_WORDS);

  smw_fab_t      fstate;
  logic          own;
  logic [3:0]    split_cnt;
  logic          d_valid;
  logic          d_write;
  logic [IW-1:0] d_idx;
  logic [DW-1:0] mem [MEM_WORDS];

  // Any NONSEQ is accepted, even mid-burst, so early-ended bursts are fine
  wire           take   = bus.hready & own & bus.htrans[1];
  wire [IW-1:0]  a_idx  = bus.haddr[IW+1:2];
  wire           ans_ok = i_resp_sel == RESP_OKAY;
  wire           wr_now = d_valid & d_write & bus.hready;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      own       <= 1'b0;
      split_cnt <= 4'h0;
      bus.hgrant <= 1'b0;
    end else begin
      if (bus.hready) begin
        own <= bus.hgrant;
      end
      if (take && i_resp_sel == RESP_SPLIT) begin
        split_cnt <= SPLIT_HOLD_CYC;
      end else if (split_cnt != 4'h0) begin
        split_cnt <= split_cnt - 4'h1;
      end
      // A locked sequence keeps the grant while i_grant_hold is set; a SPLIT hold-off still removes it
      bus.hgrant <= ~(i_grant_hold & ~bus.hlock) & (split_cnt == 4'h0);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      fstate     <= FS_OK;
      bus.hready <= 1'b1;
      bus.hresp  <= RESP_OKAY;
      bus.hrdata <= '0;
      d_valid    <= 1'b0;
      d_write    <= 1'b0;
      d_idx      <= '0;
    end else begin
      case (fstate)
        FS_OK: begin
          bus.hresp <= RESP_OKAY;
          if (bus.hready) begin
            d_valid <= take & ans_ok;
          end
          if (take) begin
            d_write <= bus.hwrite;
            d_idx   <= a_idx;
            if (ans_ok) begin
              bus.hrdata <= mem[a_idx];
            end else begin
              bus.hready <= 1'b0;
              bus.hresp  <= i_resp_sel;
              fstate     <= FS_RESP2;
            end
          end
        end
        default: begin
          bus.hready <= 1'b1;
          fstate     <= FS_OK;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (wr_now) begin
      mem[d_idx] <= bus.hwdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_addr_seen  <= '0;
      o_trans_seen <= TR_IDLE;
      o_burst_seen <= BU_SINGLE;
      o_lock_seen  <= 1'b0;
    end else if (take) begin
      o_addr_seen  <= bus.haddr;
      o_trans_seen <= bus.htrans;
      o_burst_seen <= bus.hburst;
      o_lock_seen  <= bus.hlock;
    end
  end

endmodule // smw_fabric

// file: smw_assertions.sv
/* Bus-side checks between wrapper and fabric.
   Assumes plain copies of the interface signals. */
`timescale 1ns/100ps
module smw_assertions
  import smw_pkg::*;
#(
  parameter int AW = 32
) (
  input wire logic          i_clk_sys,
  input wire logic          i_rstn,
  input wire logic          hbusreq,
  input wire logic          hlock,
  input wire logic          hgrant,
  input wire logic [1:0]    htrans,
  input wire logic [AW-1:0] haddr,
  input wire logic [2:0]    hburst,
  input wire logic          hready,
  input wire logic [1:0]    hresp
);
  logic [AW-1:0] taken_addr;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) taken_addr <= '0;
    else if (hready && htrans[1]) taken_addr <= haddr;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  sequence s_bad_first;
    !hready && hresp != RESP_OKAY;
  endsequence
  sequence s_retry_end;
    hready && hresp == RESP_RETRY;
  endsequence
  sequence s_reissue;
    htrans == TR_NONSEQ && haddr == taken_addr;
  endsequence
  a_req_with_trans: assert property (htrans[1] |-> hbusreq)
    else $error("request low during transfer");
  a_trans_granted: assert property (htrans[1] && hready |-> $past(hgrant))
    else $error("transfer without grant");
  a_resp_two_cycle: assert property (s_bad_first |=> hready && hresp == $past(hresp))
    else $error("response not two cycles");
  a_retry_idle: assert property (!hready && hresp == RESP_RETRY |-> htrans == TR_IDLE)
    else $error("no idle during retry");
  a_retry_reissue: assert property (s_retry_end or hready && hresp == RESP_SPLIT
    |-> ##[1:20] s_reissue) else $error("address not reissued");
  a_lock_steady: assert property (htrans == TR_SEQ |-> $stable(hlock))
    else $error("lock moved in burst");
  a_lock_grant: assert property (hlock && hgrant && hresp != RESP_SPLIT |=> hgrant)
    else $error("grant lost while locked");
  a_seq_burst: assert property (htrans == TR_SEQ |-> hburst != BU_SINGLE)
    else $error("sequential beat in single");
endmodule // smw_assertions

// file: single_master_bus_wrapper_tb_top.sv
/* Testbench joining wrapper and fabric through the bus interface.
   Assumes one 250 MHz clock and active-low reset. */
`timescale 1ns/100ps
module single_master_bus_wrapper_tb_top
  import smw_pkg::*;
;
  localparam logic [31:0] MA = 32'h0000_0008;
  localparam logic [31:0] MD = 32'hA5A5_1234;
  logic        i_clk_sys, i_rstn, grant_hold, lock, wr, err;
  logic [1:0]  trans, resp_sel;
  logic [2:0]  burst;
  logic [31:0] addr, wdata, rdata;
  wire         lite_ready, lite_resp, lock_seen;
  wire  [31:0] lite_rdata, addr_seen;
  wire  [1:0]  trans_seen;
  wire  [2:0]  burst_seen;
  int          num_errors, n_checks;
  smw_ahb_if bus_if ();
  smw_wrapper smw_wrapper_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .bus(bus_if.mst),
    .i_lite_htrans(trans), .i_lite_haddr(addr), .i_lite_hwrite(wr), .i_lite_hsize(3'h2),
    .i_lite_hburst(burst), .i_lite_hmastlock(lock), .i_lite_hwdata(wdata),
    .o_lite_hready(lite_ready), .o_lite_hresp(lite_resp), .o_lite_hrdata(lite_rdata));
  smw_fabric smw_fabric_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .bus(bus_if.fab),
    .i_grant_hold(grant_hold), .i_resp_sel(resp_sel), .o_addr_seen(addr_seen),
    .o_trans_seen(trans_seen), .o_burst_seen(burst_seen), .o_lock_seen(lock_seen));
  smw_assertions smw_assertions_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .hbusreq(bus_if.hbusreq), .hlock(bus_if.hlock), .hgrant(bus_if.hgrant),
    .htrans(bus_if.htrans), .haddr(bus_if.haddr), .hburst(bus_if.hburst),
    .hready(bus_if.hready), .hresp(bus_if.hresp));
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
      num_errors++;
    end
  endtask
  // Inputs held until ready returns; next address phase goes idle
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk_sys);
    trans <= TR_NONSEQ;
    addr <= a;
    wr <= w;
    wdata <= d;
    k = 0;
    do begin @(negedge i_clk_sys); k++; end while (lite_ready !== 1'b1 && k < 50);
    if (lite_ready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    @(posedge i_clk_sys);
    trans <= TR_IDLE;
    do begin @(negedge i_clk_sys); k++; end while (lite_ready !== 1'b1 && k < 250);
    rdata = lite_rdata;
    err = lite_resp;
    if (k >= 250) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic t_wr_rd();
    xfer(1'b1, MA, MD);
    chk({31'h0, err}, 32'h0);
    xfer(1'b0, MA, 32'h0);
    chk(rdata, MD);
    chk(addr_seen, MA);
    chk({30'h0, trans_seen}, {30'h0, TR_NONSEQ});
  endtask
  task automatic t_error();
    @(posedge i_clk_sys);
    resp_sel <= RESP_ERROR;
    xfer(1'b0, MA, 32'h0);
    chk({31'h0, err}, 32'h1);
    @(posedge i_clk_sys);
    resp_sel <= RESP_OKAY;
  endtask
  task automatic t_restart(input logic [1:0] code);
    int k;
    @(posedge i_clk_sys);
    resp_sel <= code;
    fork
      xfer(1'b0, MA, 32'h0);
      begin
        k = 0;
        while (bus_if.hresp !== code && k < 50) begin @(negedge i_clk_sys); k++; end
        if (bus_if.hresp !== code) begin
          num_errors++;
          give_verdict();
        end
        @(posedge i_clk_sys);
        resp_sel <= RESP_OKAY;
      end
    join
    chk(rdata, MD);
    chk({31'h0, err}, 32'h0);
  endtask
  task automatic t_no_grant();
    @(posedge i_clk_sys);
    grant_hold <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    fork
      xfer(1'b0, MA, 32'h0);
      begin
        repeat (10) @(negedge i_clk_sys);
        chk({31'h0, lite_ready}, 32'h0);
        chk({31'h0, bus_if.hbusreq}, 32'h1);
        @(posedge i_clk_sys);
        grant_hold <= 1'b0;
      end
    join
    chk(rdata, MD);
  endtask
  task automatic t_lock();
    @(posedge i_clk_sys);
    lock <= 1'b1;
    xfer(1'b0, MA, 32'h0);
    chk({31'h0, lock_seen}, 32'h1);
    @(posedge i_clk_sys);
    lock <= 1'b0;
    xfer(1'b0, MA, 32'h0);
    chk({31'h0, lock_seen}, 32'h0);
  endtask
  // Two-beat burst, SEQ held while ready is low; cut drops grant after beat one
  task automatic t_burst(input logic cut);
    int k;
    @(posedge i_clk_sys);
    trans <= TR_NONSEQ;
    addr  <= MA;
    wr    <= 1'b0;
    burst <= BU_INCR;
    @(posedge i_clk_sys);
    trans      <= TR_SEQ;
    addr       <= MA + 32'h4;
    grant_hold <= cut;
    k = 0;
    do begin @(negedge i_clk_sys); k++; end while (lite_ready !== 1'b1 && k < 50);
    if (lite_ready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    chk(lite_rdata, MD);
    chk(addr_seen, MA);
    chk({29'h0, burst_seen}, {29'h0, BU_INCR});
    @(posedge i_clk_sys);
    trans      <= TR_IDLE;
    burst      <= BU_SINGLE;
    grant_hold <= 1'b0;
    do begin @(negedge i_clk_sys); k++; end while (lite_ready !== 1'b1 && k < 100);
    if (lite_ready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    chk(addr_seen, MA + 32'h4);
    chk({30'h0, trans_seen}, {30'h0, cut ? TR_NONSEQ : TR_SEQ});
    chk({29'h0, burst_seen}, {29'h0, BU_INCR});
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    {i_rstn, grant_hold, lock, wr} = 4'h0;
    trans = TR_IDLE;
    burst = BU_SINGLE;
    resp_sel = RESP_OKAY;
    {addr, wdata} = 64'h0;
    num_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    t_wr_rd();
    t_error();
    t_restart(RESP_RETRY);
    t_restart(RESP_SPLIT);
    t_no_grant();
    t_lock();
    t_burst(1'b0);
    t_burst(1'b1);
    give_verdict();
  end
endmodule // single_master_bus_wrapper_tb_top
